// *** verilog/eqc_cmd.sv ***
// Error queue, message filter and pole-count configuration commands
// Assumes a parser upstream: one command per cmdValid pulse, lists as masks
`timescale 1ns/10ps
`include "eqc_regs.svh"
// Overview of operation
// R1: Each of two relays keeps its own pole count; only 4 or 6 accepted.
// R2: Pole query answers the count now set for that relay.
// R3: Status defaults command restores filter mask; it has no query form.
// R4: Queue holds at most ten messages.
// R5: Queue is first-in first-out; each read returns and removes oldest.
// R6: Filling the last slot stores overflow code 350 instead.
// R7: Queue is empty after power-up.
// R8: Reading an empty queue answers code 0, no error.
// R9: Each queued message carries its numeric code.
// R10: At power-up status messages blocked, errors accepted; only accepted ones queue.
// R11: Accept list first blocks all codes, then accepts exactly listed ones.
// R12: Empty accept list leaves every code blocked.
// R13: Block list blocks listed codes, others unchanged.
// R14: Accept query answers the codes currently accepted.
// R15: Block query answers the codes currently blocked.
// R16: Both flush commands empty the queue; neither has a query form.
// R17: Status pop query and system error query behave identically.
// R18: An answer leaves only after the query and then talk addressing.
// R19: Version query answers the command-language version.
// R20: Serial query answers the serial number only.
// R21: Mask is checked when an event posts; blocked events use no space.
module eqc_cmd #(
  parameter int NCODES = 32,
  parameter logic [NCODES-1:0] STATUS_CODES = '0,
  parameter logic [31:0] LANG_VERSION = `EQC_VERSION_DEFAULT,
  parameter logic [31:0] SERIAL_NUMBER = `EQC_SERIAL_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire eqc_pkg::eqc_cmd_e cmdOp,
  input wire logic cmdRelay,
  input wire logic [2:0] cmdPoles,
  input wire logic [NCODES-1:0] cmdList,
  input wire logic evtValid,
  input wire logic [4:0] evtIndex,
  input wire logic [15:0] evtCode,
  input wire logic talkAddressed,
  output logic rspValid,
  output logic [31:0] rspData,
  output logic cmdReject,
  output logic [3:0] queueCount
);
  import eqc_pkg::*;

  localparam int DEPTH = `EQC_QUEUE_DEPTH;

  initial
  begin
    if (NCODES < 1 || NCODES > 32)
    begin
      $error("eqc_cmd: NCODES must lie in 1..32");
    end
    // Count and pointers are four bits wide
    if (DEPTH < 2 || DEPTH > 15)
    begin
      $error("eqc_cmd: queue depth must lie in 2..15");
    end
  end

  typedef struct packed {
    logic [2:0] pole0;
    logic [2:0] pole1;
    logic [NCODES-1:0] accept;
    logic [DEPTH-1:0][15:0] slot;
    logic [3:0] head;
    logic [3:0] count;
    logic pending;
    logic [31:0] answer;
    logic rspValid;
    logic [31:0] rspData;
    logic reject;
  } eqc_state_s;

  eqc_state_s st;
  eqc_state_s next_st;

  function automatic logic [3:0] wrapIdx(input logic [3:0] base, input logic [3:0] off);
    logic [4:0] sum;
    sum = {1'b0, base} + {1'b0, off};
    if (sum >= 5'(DEPTH))
    begin
      sum = sum - 5'(DEPTH);
    end
    return sum[3:0];
  endfunction

  function automatic eqc_state_s resetState();
    eqc_state_s r;
    r = '0;
    r.pole0 = `EQC_POLES_RESET;
    r.pole1 = `EQC_POLES_RESET;
    r.accept = ~STATUS_CODES; // R10
    return r;
  endfunction

  // Only the two documented pole counts may be stored
  function automatic logic poleLegal(input logic [2:0] poles);
    return (poles == `EQC_POLES_FOUR) || (poles == `EQC_POLES_SIX);
  endfunction

  function automatic logic [31:0] poleAnswer(input logic [2:0] poles);
    return {29'h0, poles};
  endfunction

  // Queue answers carry the code in the low half, upper half zero
  function automatic logic [31:0] codeAnswer(input logic [15:0] code);
    return {16'h0, code};
  endfunction

  function automatic logic [31:0] maskAnswer(input logic [NCODES-1:0] mask);
    logic [31:0] r;
    r = '0;
    r[NCODES-1:0] = mask;
    return r;
  endfunction

  function automatic logic queueEmpty(input logic [3:0] level);
    return level == 4'h0;
  endfunction

  function automatic logic queueFull(input logic [3:0] level);
    return level >= 4'(DEPTH);
  endfunction

  // The last free slot takes the overflow marker, not the event
  function automatic logic lastSlot(input logic [3:0] level);
    return level == 4'(DEPTH - 1);
  endfunction

  // Indices beyond the mask are never accepted
  function automatic logic codeAccepted(input logic [NCODES-1:0] mask, input logic [4:0] idx);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j < NCODES; j++)
    begin
      if (5'(j) == idx)
      begin
        hit = mask[j];
      end
    end
    return hit;
  endfunction

  function automatic logic isQuery(input eqc_cmd_e op);
    logic q;
    case (op)
      EQC_POLE_QUERY, EQC_QUEUE_POP, EQC_SYS_ERROR_POP, EQC_ACCEPT_QUERY,
        EQC_BLOCK_QUERY, EQC_VERSION_QUERY, EQC_SERIAL_QUERY:
        q = 1'b1;
      default:
        q = 1'b0;
    endcase
    return q;
  endfunction

  // Both pop queries share one path; an empty queue answers no error
  function automatic eqc_state_s popQueue(input eqc_state_s s);
    eqc_state_s r;
    logic [15:0] code;
    r = s;
    code = `EQC_CODE_NO_ERROR;
    if (!queueEmpty(s.count))
    begin
      code = s.slot[s.head]; // R5
      r.head = wrapIdx(s.head, 4'h1);
      r.count = s.count - 4'h1;
    end
    r.answer = codeAnswer(code); // R8 R9
    r.pending = 1'b1;
    return r;
  endfunction

  // Flush keeps stored words; only the pointers move
  function automatic eqc_state_s flushQueue(input eqc_state_s s);
    eqc_state_s r;
    r = s;
    r.count = 4'h0; // R16
    r.head = 4'h0;
    return r;
  endfunction

  // Event stage runs on the state after this cycle's pop or flush
  function automatic eqc_state_s postEvent(input eqc_state_s s, input logic take,
    input logic [15:0] code);
    eqc_state_s r;
    logic [3:0] tail;
    r = s;
    tail = wrapIdx(s.head, s.count);
    if (take && !queueFull(s.count)) // R4
    begin
      if (lastSlot(s.count))
      begin
        r.slot[tail] = `EQC_CODE_OVERFLOW; // R6
      end
      else
      begin
        r.slot[tail] = code; // R9
      end
      r.count = s.count + 4'h1;
    end
    return r;
  endfunction

  // A query loaded in the same cycle as talk stays pending, not lost
  function automatic eqc_state_s serveTalk(input eqc_state_s s, input logic go,
    input logic fresh, input logic [31:0] ans);
    eqc_state_s r;
    r = s;
    if (go) // R18
    begin
      r.rspValid = 1'b1;
      r.rspData = ans;
      r.pending = fresh;
    end
    return r;
  endfunction

  always_comb
  begin
    logic accepted;
    logic fresh;
    next_st = st;
    accepted = 1'b0;
    fresh = 1'b0;
    next_st.rspValid = 1'b0;
    next_st.reject = 1'b0;
    if (cmdValid)
    begin
      case (cmdOp)
        EQC_NOP:
        begin
          next_st.reject = 1'b0;
        end

        EQC_POLE_SET:
        begin
          if (poleLegal(cmdPoles)) // R1
          begin
            if (cmdRelay)
            begin
              next_st.pole1 = cmdPoles;
            end
            else
            begin
              next_st.pole0 = cmdPoles;
            end
          end
          else
          begin
            next_st.reject = 1'b1;
          end
        end

        EQC_POLE_QUERY:
        begin
          next_st.answer = poleAnswer(cmdRelay ? st.pole1 : st.pole0); // R2
          next_st.pending = 1'b1;
        end

        EQC_STATUS_DEFAULTS:
        begin
          next_st.accept = ~STATUS_CODES; // R3
        end

        EQC_QUEUE_POP:
        begin
          next_st = popQueue(next_st); // R5 R17
        end

        EQC_SYS_ERROR_POP:
        begin
          next_st = popQueue(next_st); // R17
        end

        EQC_ACCEPT_LIST:
        begin
          next_st.accept = cmdList; // R11 R12
        end

        EQC_BLOCK_LIST:
        begin
          next_st.accept = st.accept & ~cmdList; // R13
        end

        EQC_ACCEPT_QUERY:
        begin
          next_st.answer = maskAnswer(st.accept); // R14
          next_st.pending = 1'b1;
        end

        EQC_BLOCK_QUERY:
        begin
          next_st.answer = maskAnswer(~st.accept); // R15
          next_st.pending = 1'b1;
        end

        EQC_QUEUE_FLUSH:
        begin
          next_st = flushQueue(next_st); // R16
        end

        EQC_SYS_FLUSH:
        begin
          next_st = flushQueue(next_st); // R16
        end

        EQC_VERSION_QUERY:
        begin
          next_st.answer = LANG_VERSION; // R19
          next_st.pending = 1'b1;
        end

        EQC_SERIAL_QUERY:
        begin
          next_st.answer = SERIAL_NUMBER; // R20
          next_st.pending = 1'b1;
        end

        default:
        begin
          next_st.reject = 1'b1;
        end
      endcase
    end
    // Event after any pop or flush of the same cycle, so it sees the room they free
    accepted = evtValid && codeAccepted(st.accept, evtIndex); // R21
    fresh = cmdValid && isQuery(cmdOp);
    next_st = postEvent(next_st, accepted, evtCode);
    next_st = serveTalk(next_st, st.pending && talkAddressed, fresh, st.answer); // R18
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= resetState(); // R7
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rspValid = st.rspValid;
  assign rspData = st.rspData;
  assign cmdReject = st.reject;
  assign queueCount = st.count;
endmodule // eqc_cmd

// *** verilog/eqc_regs.svh ***
// Constants of the error queue and configuration command block
// Assumes inclusion by eqc_cmd only
`ifndef EQC_REGS_SVH
`define EQC_REGS_SVH
`define EQC_QUEUE_DEPTH 10
`define EQC_CODE_NO_ERROR 16'h0000
`define EQC_CODE_OVERFLOW 16'h015e
`define EQC_POLES_FOUR 3'h4
`define EQC_POLES_SIX 3'h6
`define EQC_POLES_RESET 3'h4
`define EQC_VERSION_DEFAULT 32'h00000001
`define EQC_SERIAL_DEFAULT 32'h00000000
`endif

// *** verilog/eqc_pkg.sv ***
// Types of the error queue and configuration command block
// Commands arrive already parsed from the instrument bus
package eqc_pkg;
  typedef enum logic [3:0] {
    EQC_NOP = 4'h0,
    EQC_POLE_SET = 4'h1,
    EQC_POLE_QUERY = 4'h2,
    EQC_STATUS_DEFAULTS = 4'h3,
    EQC_QUEUE_POP = 4'h4,
    EQC_SYS_ERROR_POP = 4'h5,
    EQC_ACCEPT_LIST = 4'h6,
    EQC_ACCEPT_QUERY = 4'h7,
    EQC_BLOCK_LIST = 4'h8,
    EQC_BLOCK_QUERY = 4'h9,
    EQC_QUEUE_FLUSH = 4'ha,
    EQC_SYS_FLUSH = 4'hb,
    EQC_VERSION_QUERY = 4'hc,
    EQC_SERIAL_QUERY = 4'hd
  } eqc_cmd_e;
endpackage

// *** test/eqc_cmd_sva.sv ***
// Port checker of the error queue block
// Bound onto every eqc_cmd instance
`timescale 1ns/10ps
module eqc_cmd_sva #(
  parameter int NCODES = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire eqc_pkg::eqc_cmd_e cmdOp,
  input wire logic [2:0] cmdPoles,
  input wire logic evtValid,
  input wire logic talkAddressed,
  input wire logic rspValid,
  input wire logic [31:0] rspData,
  input wire logic cmdReject,
  input wire logic [3:0] queueCount
);
  import eqc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic pop, setp;
  assign pop = cmdValid && cmdOp inside {EQC_QUEUE_POP, EQC_SYS_ERROR_POP};
  assign setp = cmdValid && cmdOp == EQC_POLE_SET;
  property p_bad; setp && !(cmdPoles inside {3'h4, 3'h6}) |=> cmdReject; endproperty
  a_bad: assert property (p_bad) else $error("bad pole kept");
  property p_good; setp && cmdPoles inside {3'h4, 3'h6} |=> !cmdReject; endproperty
  a_good: assert property (p_good) else $error("good pole refused");
  property p_depth; queueCount <= 4'ha; endproperty
  a_depth: assert property (p_depth) else $error("queue too deep");
  property p_pop; pop && !evtValid && queueCount != 0 |=> queueCount == $past(queueCount) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop count");
  property p_empty; pop && queueCount == 0 ##1 talkAddressed && !cmdValid
    |=> rspValid && rspData == 32'h0; endproperty
  a_empty: assert property (p_empty) else $error("empty pop");
  property p_flush; cmdValid && cmdOp inside {EQC_QUEUE_FLUSH, EQC_SYS_FLUSH} && !evtValid
    |=> queueCount == 4'h0; endproperty
  a_flush: assert property (p_flush) else $error("flush");
  property p_idle; !cmdValid && !evtValid |=> $stable(queueCount); endproperty
  a_idle: assert property (p_idle) else $error("count moved");
  property p_talk; rspValid |-> $past(talkAddressed); endproperty
  a_talk: assert property (p_talk) else $error("answer untalked");
  c_full: cover property (pop && queueCount == 4'ha);
  c_rej: cover property (cmdReject);
  c_rsp: cover property (rspValid);
endmodule // eqc_cmd_sva
bind eqc_cmd eqc_cmd_sva #(.NCODES(NCODES)) i_sva (.clk_sys, .nrst, .cmdValid, .cmdOp,
  .cmdPoles, .evtValid, .talkAddressed, .rspValid, .rspData, .cmdReject, .queueCount);

// *** test/eqc_host_model.sv ***
// Host model: addresses the unit to talk a few cycles after each command
// Assumes one-cycle cmdValid strobes
`timescale 1ns/10ps
module eqc_host_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic [1:0] lag,
  output logic talkAddressed
);
  logic [2:0] cnt;
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      cnt <= 3'h0;
      talkAddressed <= 1'b0;
    end
    else
    begin
      talkAddressed <= cnt == 3'h1;
      cnt <= cmdValid ? {1'b0, lag} + 3'h1 : cnt - {2'h0, cnt != 3'h0};
    end
endmodule // eqc_host_model

// *** test/tb_top.sv ***
// Bench of the error queue block, random codes with corner cases
// Host model gives the talk addressing
`timescale 1ns/10ps
module tb_top;
  import eqc_pkg::*;
  logic clk_sys = 0, nrst = 0, cmdValid = 0, cmdRelay = 0, evtValid = 0;
  logic talkAddressed, rspValid, cmdReject;
  eqc_cmd_e cmdOp = EQC_NOP;
  logic [2:0] cmdPoles = 3'h4;
  logic [31:0] cmdList = '0, rspData, m, b;
  logic [4:0] evtIndex = '0;
  logic [15:0] evtCode = '0, q[$];
  logic [1:0] lag = '0;
  logic [3:0] queueCount;
  int mismatches = 0, checks = 0, seed = 32'hfd7d1762, i, k;
  eqc_cmd #(.LANG_VERSION(32'h00000002), .SERIAL_NUMBER(32'h00005a5a)) i_dut (.clk_sys,
    .nrst, .cmdValid, .cmdOp, .cmdRelay, .cmdPoles, .cmdList, .evtValid, .evtIndex,
    .evtCode, .talkAddressed, .rspValid, .rspData, .cmdReject, .queueCount);
  eqc_host_model i_host (.clk_sys, .nrst, .cmdValid, .lag, .talkAddressed);
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmd(input eqc_cmd_e op, input logic [31:0] a);
    @(posedge clk_sys);
    cmdValid <= 1;
    cmdOp <= op;
    cmdList <= a;
    cmdPoles <= a[2:0];
    cmdRelay <= a[31];
    lag <= 2'($random(seed));
    @(posedge clk_sys);
    cmdValid <= 0;
  endtask
  task automatic qry(input eqc_cmd_e op, input logic [31:0] a, e, input string n);
    cmd(op, a);
    for (i = 0; i < 9 && rspValid !== 1'b1; i++)
      @(negedge clk_sys);
    chk(n, e, rspData);
  endtask
  task automatic evt(input logic [31:0] v);
    @(posedge clk_sys);
    evtValid <= 1;
    evtIndex <= v[4:0];
    evtCode <= v[31:16];
    @(posedge clk_sys);
    evtValid <= 0;
  endtask
  task automatic rej(input logic [31:0] e);
    @(negedge clk_sys);
    chk("reject", e, cmdReject);
  endtask
  task automatic cnt(input logic [3:0] e);
    @(negedge clk_sys);
    chk("count", e, queueCount);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1;
    cnt(0);
    qry(EQC_QUEUE_POP, 0, 0, "empty");
    qry(EQC_POLE_QUERY, 32'h80000000, 4, "pole2");
    cmd(EQC_POLE_SET, 32'h80000006);
    rej(0);
    cmd(EQC_POLE_SET, 32'h5);
    rej(1);
    cmd(eqc_cmd_e'(4'he), 0);
    rej(1);
    qry(EQC_POLE_QUERY, 32'h80000000, 6, "pole2");
    qry(EQC_POLE_QUERY, 0, 4, "pole1");
    $display("pole test done");
    for (k = 0; k < 12; k++)
    begin
      m = $random(seed);
      evt(m);
      if (q.size() < 10)
        q.push_back(q.size() == 9 ? 16'h015e : m[31:16]);
    end
    cnt(10);
    for (k = 0; k < 11; k++)
      qry(k[0] ? EQC_SYS_ERROR_POP : EQC_QUEUE_POP, 0, k < 10 ? q[k] : 0, "pop");
    $display("queue test done");
    m = $random(seed);
    b = $random(seed);
    cmd(EQC_ACCEPT_LIST, m);
    qry(EQC_ACCEPT_QUERY, 0, m, "accept");
    cmd(EQC_BLOCK_LIST, b);
    qry(EQC_BLOCK_QUERY, 0, ~(m & ~b), "block");
    cmd(EQC_ACCEPT_LIST, 0);
    evt(m);
    cnt(0);
    cmd(EQC_STATUS_DEFAULTS, 0);
    qry(EQC_ACCEPT_QUERY, 0, 32'hffffffff, "preset");
    evt(b);
    evt(m);
    cmd(EQC_QUEUE_FLUSH, 0);
    cnt(0);
    evt(b);
    cmd(EQC_SYS_FLUSH, 0);
    cnt(0);
    qry(EQC_VERSION_QUERY, 0, 32'h00000002, "version");
    qry(EQC_SERIAL_QUERY, 0, 32'h00005a5a, "serial");
    $display("mask test done");
    final_report;
  end
  initial
  begin
    #200000;
    mismatches++;
    final_report;
  end
endmodule // tb_top
